// >>> dpsc_pkg.sv
// constants and types shared by the dual potentiometer serial command decoder
package dpsc_pkg;

   // ---------------------------------------------------------------
   // serial word layout
   // ---------------------------------------------------------------
   localparam int unsigned DPSC_WORD_BITS    = 16;
   localparam int unsigned DPSC_CMD_MSB      = 15;
   localparam int unsigned DPSC_CMD_LSB      = 12;
   localparam int unsigned DPSC_ALL_CH_POS   = 11;
   localparam int unsigned DPSC_BANK_POS     = 10;
   localparam int unsigned DPSC_NVM_CH_POS   = 9;
   localparam int unsigned DPSC_CH_POS       = 8;
   localparam int unsigned DPSC_GAIN_BIT_POS = 2;
   localparam int unsigned DPSC_D0_POS       = 0;

   // ---------------------------------------------------------------
   // frame length check
   // ---------------------------------------------------------------
   localparam logic [5:0] DPSC_FRAME_MIN  = 6'h10;
   localparam logic [5:0] DPSC_FRAME_MAX  = 6'h20;
   localparam logic [5:0] DPSC_FRAME_SAT  = 6'h3F;
   localparam logic [2:0] DPSC_UNIT_MASK  = 3'h7;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [3:0] DPSC_CMD_NOP       = 4'h0;
   localparam logic [3:0] DPSC_CMD_WIPER_WR  = 4'h1;
   localparam logic [3:0] DPSC_CMD_PRELOAD_WR = 4'h2;
   localparam logic [3:0] DPSC_CMD_READBACK  = 4'h3;
   localparam logic [3:0] DPSC_CMD_XFER      = 4'h8;
   localparam logic [3:0] DPSC_CMD_NVM_COPY  = 4'h9;
   localparam logic [3:0] DPSC_CMD_CTRL_WR   = 4'hD;
   localparam logic [3:0] DPSC_CMD_SOFT_RST  = 4'hE;
   localparam logic [3:0] DPSC_CMD_SHUTDOWN  = 4'hF;

   localparam logic [1:0] DPSC_RB_NVM        = 2'h1;
   localparam logic [1:0] DPSC_RB_WIPER      = 2'h3;

   // ---------------------------------------------------------------
   // register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [4:0] DPSC_REG_STATUS    = 5'h00;
   localparam logic [4:0] DPSC_REG_CTRL      = 5'h04;
   localparam logic [4:0] DPSC_REG_WIPER     = 5'h08;
   localparam logic [4:0] DPSC_REG_PRELOAD   = 5'h0C;
   localparam logic [4:0] DPSC_REG_NVM       = 5'h10;

   localparam int unsigned DPSC_ST_GAIN_POS  = 0;
   localparam int unsigned DPSC_ST_STRAP_POS = 1;
   localparam int unsigned DPSC_ST_SHDN_POS  = 2;
   localparam int unsigned DPSC_ST_GBIT_POS  = 3;
   localparam int unsigned DPSC_ST_BAD_LSB   = 8;
   localparam int unsigned DPSC_CTRL_EN_POS  = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] DPSC_NVM_RST       = 8'h80;
   localparam logic [7:0] DPSC_WIPER_RST     = 8'h80;
   localparam logic       DPSC_EN_RST        = 1'b1;

   typedef enum logic {DPSC_BUS_IDLE, DPSC_BUS_ACK} dpsc_bus_state_t;

endpackage : dpsc_pkg

// >>> dpsc_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dpsc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // no reset: stages settle while reset is held two or more edges
   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
   end
endmodule : dpsc_sync
`default_nettype wire

// >>> dpsc_decoder.sv
// serial command decoder, preload and wiper registers, bus slave
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dpsc_decoder
   import dpsc_pkg::*;
#(
   parameter int unsigned DW = 8
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        frame_sel_n_i,
   input  wire logic        sclk_i,
   input  wire logic        sdi_i,
   input  wire logic        split_string_strap_i,
   output var  logic        sdo_o,
   output var  logic        sdo_oe_o,
   output var  logic [DW-1:0] wiper_ch1_o,
   output var  logic [DW-1:0] wiper_ch2_o,
   output var  logic [DW-1:0] wiper2_ch1_o,
   output var  logic [DW-1:0] wiper2_ch2_o,
   output var  logic        gain_mode_o,
   output var  logic        shutdown_o,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o
);
   import dpsc_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisation and edge detection
   // ---------------------------------------------------------------
   logic [3:0]  pins_s;
   logic        fsel_n_p_q, sclk_p_q, init_q, strap_q;
   logic        gain_bit_q, gain_q, shdn_q, en_q, oe_q;
   logic [5:0]  cnt_q;
   logic [15:0] sr_q;
   logic [7:0]  bad_q;
   logic [DW-1:0] wiper_q [4];
   logic [DW-1:0] pre_q   [4];
   logic [DW-1:0] nvm_q   [4];
   dpsc_bus_state_t bus_q;
   logic        wait_q;
   logic [31:0] rdata_q;

   dpsc_sync #(.W(4)) u_sync (
      .clk_i (clk_i),
      .d_i   ({split_string_strap_i, sdi_i, sclk_i, frame_sel_n_i}),
      .q_o   (pins_s)
   );

   wire fsel_n_s  = pins_s[0];
   wire sclk_s    = pins_s[1];
   wire sdi_s     = pins_s[2];
   wire strap_s   = pins_s[3];
   wire in_frame  = ~fsel_n_s & en_q;
   wire sclk_fall = sclk_p_q & ~sclk_s;
   wire sclk_rise = ~sclk_p_q & sclk_s;
   wire fsel_fall = fsel_n_p_q & ~fsel_n_s;
   wire fsel_rise = ~fsel_n_p_q & fsel_n_s;

   // ---------------------------------------------------------------
   // frame check and command fields
   // ---------------------------------------------------------------
   wire cnt_ok = ((cnt_q[2:0] & DPSC_UNIT_MASK) == 3'h0)
                 && (cnt_q >= DPSC_FRAME_MIN) && (cnt_q <= DPSC_FRAME_MAX);
   wire exec   = fsel_rise & en_q & cnt_ok;
   wire bad    = fsel_rise & en_q & ~cnt_ok & (cnt_q != 6'h00);
   wire [3:0] cmd  = sr_q[DPSC_CMD_MSB:DPSC_CMD_LSB];
   wire [7:0] data = sr_q[7:0];
   wire all_ch     = sr_q[DPSC_ALL_CH_POS];
   wire bank_sel   = gain_q & sr_q[DPSC_BANK_POS];
   wire [1:0] ch_idx  = {bank_sel, sr_q[DPSC_CH_POS]};
   wire [1:0] nvm_idx = {bank_sel, sr_q[DPSC_NVM_CH_POS]};
   wire [1:0] rb_sel  = data[1:0];
   wire [DW-1:0] rb_val = (rb_sel == DPSC_RB_NVM)   ? nvm_q[nvm_idx] :
                          (rb_sel == DPSC_RB_WIPER) ? wiper_q[ch_idx] :
                          pre_q[ch_idx];
   wire do_wr    = exec & (cmd == DPSC_CMD_WIPER_WR);
   wire do_pre   = exec & (cmd == DPSC_CMD_PRELOAD_WR);
   wire do_rb    = exec & (cmd == DPSC_CMD_READBACK);
   wire do_xfer  = exec & (cmd == DPSC_CMD_XFER);
   wire do_store = exec & (cmd == DPSC_CMD_NVM_COPY) & data[DPSC_D0_POS];
   wire do_rest  = exec & (cmd == DPSC_CMD_NVM_COPY) & ~data[DPSC_D0_POS];
   wire do_ctrl  = exec & (cmd == DPSC_CMD_CTRL_WR);
   wire do_srst  = exec & (cmd == DPSC_CMD_SOFT_RST);
   wire do_shdn  = exec & (cmd == DPSC_CMD_SHUTDOWN);

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire bus_req  = avs_read_i | avs_write_i;
   wire bus_wr   = avs_write_i & (bus_q == DPSC_BUS_ACK);
   wire wr_ctrl  = bus_wr & (avs_address_i == DPSC_REG_CTRL);
   wire wr_nvm   = bus_wr & (avs_address_i == DPSC_REG_NVM);
   wire [31:0] st_word = {16'h0000, bad_q, 4'h0, gain_bit_q, shdn_q, strap_q, gain_q};
   wire [31:0] rd_mux =
      (avs_address_i == DPSC_REG_STATUS)  ? st_word :
      (avs_address_i == DPSC_REG_CTRL)    ? {31'h0000_0000, en_q} :
      (avs_address_i == DPSC_REG_WIPER)   ? {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]} :
      (avs_address_i == DPSC_REG_PRELOAD) ? {pre_q[3], pre_q[2], pre_q[1], pre_q[0]} :
      (avs_address_i == DPSC_REG_NVM)     ? {nvm_q[3], nvm_q[2], nvm_q[1], nvm_q[0]} :
      32'h0000_0000;

   // ---------------------------------------------------------------
   // serial shift path and frame counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fsel_n_p_q <= 1'b1;
         sclk_p_q   <= 1'b1;                                                // idle high, no false edge
         cnt_q      <= 6'h00;
         sr_q       <= 16'h0000;
         oe_q       <= 1'b0;
         bad_q      <= 8'h00;
      end else begin
         fsel_n_p_q <= fsel_n_s;
         sclk_p_q   <= sclk_s;
         if (fsel_rise) begin
            cnt_q <= 6'h00;
         end else if (in_frame && sclk_fall && cnt_q != DPSC_FRAME_SAT) begin
            cnt_q <= cnt_q + 6'h01;
         end
         if (do_rb) begin
            sr_q <= {{(16-DW){1'b0}}, rb_val};
         end else if (in_frame && sclk_fall) begin
            sr_q <= {sr_q[14:0], sdi_s};
         end
         if (!in_frame) begin
            oe_q <= 1'b0;
         end else if (fsel_fall || sclk_rise) begin
            oe_q <= ~sr_q[15];
         end
         if (bad && bad_q != 8'hFF) begin
            bad_q <= bad_q + 8'h01;
         end
      end
   end

   assign sdo_o    = 1'b0;
   assign sdo_oe_o = oe_q;

   // ---------------------------------------------------------------
   // mode, shutdown and start-up load
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         init_q     <= 1'b1;
         strap_q    <= 1'b0;
         gain_bit_q <= 1'b0;
         gain_q     <= 1'b0;
         shdn_q     <= 1'b0;
         en_q       <= DPSC_EN_RST;
      end else begin
         init_q <= 1'b0;
         if (init_q) begin
            strap_q <= strap_s;
         end
         if (do_ctrl) begin
            gain_bit_q <= data[DPSC_GAIN_BIT_POS];
         end
         gain_q <= strap_q | gain_bit_q;
         if (do_shdn) begin
            shdn_q <= data[DPSC_D0_POS];
         end
         if (wr_ctrl && avs_byteenable_i[0]) begin
            en_q <= avs_writedata_i[DPSC_CTRL_EN_POS];
         end
      end
   end

   assign gain_mode_o = gain_q;
   assign shutdown_o  = shdn_q;

   // ---------------------------------------------------------------
   // per-entry wiper, preload and stored value; entry = {bank, ch}
   // ---------------------------------------------------------------
   genvar e;
   generate
      for (e = 0; e < 4; e++) begin : g_ent
         wire sel   = (all_ch || sr_q[DPSC_CH_POS] == e[0]) && (bank_sel == e[1]);
         wire nsel  = (all_ch || sr_q[DPSC_NVM_CH_POS] == e[0]) && (bank_sel == e[1]);
         wire ld_nv = init_q || do_srst || (do_rest && nsel);
         wire ld_wr = do_wr && sel;
         wire ld_xf = do_xfer && sel;
         wire ld    = ld_nv | ld_wr | ld_xf;
         wire [DW-1:0] w_d = ld_nv ? nvm_q[e] : ld_wr ? data[DW-1:0] : pre_q[e];
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               wiper_q[e] <= DPSC_WIPER_RST;
               pre_q[e]   <= DPSC_WIPER_RST;
               nvm_q[e]   <= DPSC_NVM_RST;
            end else begin
               if (ld) begin
                  wiper_q[e] <= w_d;
                  pre_q[e]   <= w_d;
               end else if (do_pre && sel) begin
                  pre_q[e]   <= data[DW-1:0];
               end
               if (do_store && nsel) begin
                  nvm_q[e] <= wiper_q[e];
               end else if (wr_nvm && avs_byteenable_i[e]) begin
                  nvm_q[e] <= avs_writedata_i[8*e +: DW];
               end
            end
         end
      end
   endgenerate

   assign wiper_ch1_o  = wiper_q[0];
   assign wiper_ch2_o  = wiper_q[1];
   assign wiper2_ch1_o = wiper_q[2];
   assign wiper2_ch2_o = wiper_q[3];

   // ---------------------------------------------------------------
   // bus slave: one wait cycle, then answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         bus_q   <= DPSC_BUS_IDLE;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         case (bus_q)
            DPSC_BUS_IDLE: begin
               if (bus_req) begin
                  bus_q   <= DPSC_BUS_ACK;
                  wait_q  <= 1'b0;
                  rdata_q <= avs_read_i ? rd_mux : 32'h0000_0000;
               end
            end
            DPSC_BUS_ACK: begin
               bus_q  <= DPSC_BUS_IDLE;
               wait_q <= 1'b1;
            end
            default: begin
               bus_q  <= DPSC_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_bad_frame;
      @(posedge clk_i) disable iff (!resetn_i)
      (bad && bad_q != 8'hFF) |=> (bad_q == $past(bad_q) + 8'h01) && $stable(wiper_q[0]);
   endproperty
   a_bad_frame: assert property (p_bad_frame) else $error("bad frame not rejected");

   property p_cnt_clear;
      @(posedge clk_i) disable iff (!resetn_i)
      fsel_rise |=> cnt_q == 6'h00;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

   property p_wiper_wr;
      @(posedge clk_i) disable iff (!resetn_i)
      (do_wr && g_ent[0].sel && !init_q) |=> wiper_q[0] == $past(data);
   endproperty
   a_wiper_wr: assert property (p_wiper_wr) else $error("wiper write lost");

   property p_pre_wr;
      @(posedge clk_i) disable iff (!resetn_i)
      (do_pre && g_ent[1].sel && !init_q) |=> $stable(wiper_q[1]) && pre_q[1] == $past(data);
   endproperty
   a_pre_wr: assert property (p_pre_wr) else $error("preload write wrong");

   property p_readback;
      @(posedge clk_i) disable iff (!resetn_i)
      do_rb |=> sr_q[7:0] == $past(rb_val);
   endproperty
   a_readback: assert property (p_readback) else $error("readback not loaded");

   property p_xfer_all;
      @(posedge clk_i) disable iff (!resetn_i)
      (do_xfer && all_ch && !bank_sel && !init_q) |=>
         wiper_q[0] == $past(pre_q[0]) && wiper_q[1] == $past(pre_q[1]);
   endproperty
   a_xfer_all: assert property (p_xfer_all) else $error("transfer not simultaneous");

   property p_mirror;
      @(posedge clk_i) disable iff (!resetn_i)
      $changed(wiper_q[0]) |-> pre_q[0] == wiper_q[0];
   endproperty
   a_mirror: assert property (p_mirror) else $error("preload not mirrored");

   property p_gain_or;
      @(posedge clk_i) disable iff (!resetn_i)
      (strap_q || gain_bit_q) |=> gain_q;
   endproperty
   a_gain_or: assert property (p_gain_or) else $error("gain mode not forced");

   property p_shutdown;
      @(posedge clk_i) disable iff (!resetn_i)
      (do_shdn && !init_q) |=> shdn_q == $past(data[0]) && $stable(wiper_q[0]);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown wrong");

   property p_sdo_idle;
      @(posedge clk_i) disable iff (!resetn_i)
      !in_frame |=> !oe_q;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("output driven outside frame");

   property p_bus_ack;
      @(posedge clk_i) disable iff (!resetn_i)
      (bus_req && wait_q) |=> !wait_q ##1 wait_q;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

endmodule : dpsc_decoder
`default_nettype wire

// >>> dpsc_host_model.sv
// serial host model that drives frames into the decoder
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_model (
   input  wire logic clk_i,
   input  wire logic sdo_pin_i,
   output var  logic frame_sel_n_o,
   output var  logic sclk_o,
   output var  logic sdi_o
);
   initial begin
      frame_sel_n_o = 1'b1;
      sclk_o        = 1'b1;
      sdi_o         = 1'b0;
   end
   // ---------------------------------------------------------------
   // one frame of n bits, msb first; far command leads in a chain
   // ---------------------------------------------------------------
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rx);
      rx = '0;
      @(posedge clk_i);
      frame_sel_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o <= w[i];
         repeat (8) @(posedge clk_i);
         rx = {rx[30:0], sdo_pin_i};
         sclk_o <= 1'b0;
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b1;
      end
      repeat (8) @(posedge clk_i);
      frame_sel_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (16) @(posedge clk_i);
   endtask : frame
endmodule : dpsc_host_model
`default_nettype wire

// >>> dpsc_tb.sv
// self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
   import dpsc_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        clk_i, resetn_i, strap, rd, wr, wreq, sdo, sdo_oe, gm, shdn;
   logic        fsel_n, sclk, sdi, sdo_pin;
   logic [4:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata, rdata, rdv, rx;
   logic [7:0]  wip1, wip2, wip21, wip22;
   int          fail_count, checks_done, k;
   assign sdo_pin = sdo_oe ? sdo : 1'b1;
   dpsc_decoder dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .frame_sel_n_i(fsel_n),
      .sclk_i(sclk), .sdi_i(sdi), .split_string_strap_i(strap), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .wiper_ch1_o(wip1), .wiper_ch2_o(wip2), .wiper2_ch1_o(wip21),
      .wiper2_ch2_o(wip22), .gain_mode_o(gm), .shutdown_o(shdn), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));
   dpsc_host_model host_u (.clk_i(clk_i), .sdo_pin_i(sdo_pin), .frame_sel_n_o(fsel_n),
      .sclk_o(sclk), .sdi_o(sdi));
   // ---------------------------------------------------------------
   // bus and frame helpers
   // ---------------------------------------------------------------
   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         fail_count++;
         print_verdict();
      end
      rdv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic snd(input logic [31:0] w, input int n = 16);
      host_u.frame(w, n, rx);
   endtask : snd
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      `CHK("wipers", 32'h8080_8080, {wip22, wip21, wip2, wip1})
      bus(1'b1, DPSC_REG_WIPER, 32'hFFFF_FFFF);
      bus(1'b0, DPSC_REG_WIPER, 0);
      `CHK("wiper reg", 32'h8080_8080, rdv)
      bus(1'b0, DPSC_REG_CTRL, 0);
      `CHK("ctrl reg", 32'h0000_0001, rdv)
      bus(1'b1, 5'h14, 32'hFFFF_FFFF);
      bus(1'b0, 5'h14, 0);
      `CHK("unmapped", 32'h0000_0000, rdv)
   endtask : t_reset
   task automatic t_wiper();
      snd(32'h103C);
      `CHK("ch1", 8'h3C, wip1)
      `CHK("ch2", 8'h80, wip2)
      bus(1'b0, DPSC_REG_PRELOAD, 0);
      `CHK("preload", 32'h8080_803C, rdv)
      snd(32'h1855);
      `CHK("all ch", 16'h5555, {wip2, wip1})
   endtask : t_wiper
   task automatic t_xfer();
      snd(32'h21A5);
      snd(32'h2011);
      `CHK("ch2 kept", 8'h55, wip2)
      bus(1'b0, DPSC_REG_PRELOAD, 0);
      `CHK("preloads", 32'h8080_A511, rdv)
      fork
         snd(32'h8800);
         begin
            k = 0;
            while (wip1 === 8'h55 && k < 400) begin
               @(posedge clk_i);
               k++;
            end
            if (k >= 400) begin
               fail_count++;
               print_verdict();
            end
            `CHK("xfer ch2", 8'hA5, wip2)
         end
      join
      `CHK("xfer ch1", 8'h11, wip1)
   endtask : t_xfer
   task automatic t_bad();
      snd(32'h1077, 15);
      snd(32'h1077, 17);
      snd(32'h1077, 15);
      snd(32'h1077, 20);
      `CHK("bad frames", 8'h11, wip1)
      bus(1'b0, DPSC_REG_STATUS, 0);
      `CHK("bad count", 8'h04, rdv[15:8])
      bus(1'b1, DPSC_REG_CTRL, 0);
      snd(32'h1077);
      `CHK("disabled", 8'h11, wip1)
      bus(1'b1, DPSC_REG_CTRL, 1);
      snd(32'hFF1066, 24);
      `CHK("24 bits", 8'h66, wip1)
   endtask : t_bad
   task automatic t_read();
      snd(32'h3003);
      snd(32'h1234_0000, 32);
      `CHK("chain rx", 32'h0066_1234, rx)
      `CHK("nop", 8'h66, wip1)
      snd(32'h3001);
      snd(32'h2142);
      `CHK("nvm rx", 16'h0080, rx[15:0])
      snd(32'h3100);
      snd(32'h0000);
      `CHK("pre rx", 16'h0042, rx[15:0])
      `CHK("pre only", 8'hA5, wip2)
   endtask : t_read
   task automatic t_nvm();
      snd(32'h9001);
      bus(1'b0, DPSC_REG_NVM, 0);
      `CHK("stored", 32'h8080_8066, rdv)
      snd(32'h1022);
      snd(32'h9000);
      `CHK("restored", 8'h66, wip1)
      bus(1'b1, DPSC_REG_NVM, 32'h8080_4466);
      snd(32'h1833);
      snd(32'hE000);
      `CHK("soft reset", 16'h4466, {wip2, wip1})
      snd(32'hF001);
      `CHK("shdn on", 17'h1_4466, {shdn, wip2, wip1})
      snd(32'hF000);
      `CHK("shdn off", 1'b0, shdn)
   endtask : t_nvm
   task automatic t_gain();
      snd(32'hD004);
      `CHK("gain on", 9'h166, {gm, wip1})
      snd(32'h1477);
      `CHK("bank1", 16'h7766, {wip21, wip1})
      snd(32'hD000);
      `CHK("gain off", 1'b0, gm)
   endtask : t_gain
   task automatic t_strap();
      strap <= 1'b1;
      resetn_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK("strap gain", 1'b1, gm)
      `CHK("strap load", 32'h8080_8080, {wip22, wip21, wip2, wip1})
      snd(32'hD000);
      `CHK("strap or", 1'b1, gm)
      bus(1'b0, DPSC_REG_STATUS, 0);
      `CHK("status", 2'b11, rdv[1:0])
   endtask : t_strap
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      resetn_i = 1'b0;
      strap = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = '0;
      wdata = '0;
      be = 4'hF;
      fail_count = 0;
      checks_done = 0;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      t_reset();
      t_wiper();
      t_xfer();
      t_bad();
      t_read();
      t_nvm();
      t_gain();
      t_strap();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
